// [logic/fsrb_bank.sv]
// Purpose: per-framer status, control and data register bank
// Assumes: host strobes are one-cycle, synchronous to clk
// Notes: read data appears on the cycle after the read strobe

`timescale 1ns/100ps

module fsrb_bank
(
  input wire logic clk,
  input wire logic rst,
  input fsrb_pkg::fsrb_host_t host,
  output logic [7:0] host_rdata,
  input fsrb_pkg::fsrb_grp_t mon,
  input fsrb_pkg::fsrb_dp_t dp,
  output fsrb_pkg::fsrb_rw_t ctl,
  output logic rx_pop,
  output logic tx_push,
  output logic int_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsrb_pkg::fsrb_state_t q;
  fsrb_pkg::fsrb_state_t d;
  fsrb_pkg::fsrb_grp_t set_ev;
  fsrb_pkg::fsrb_grp_t clr_ev;
  fsrb_pkg::fsrb_slot_t wslot;
  logic wr_hit;
  logic rd_hit;
  logic irq_any;

  assign wr_hit = host.sel & host.wr;
  assign rd_hit = host.sel & host.rd;
  assign wslot = fsrb_pkg::fsrb_slot_of(host.addr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    set_ev = '0;
    clr_ev = '0;
    irq_any = 1'b0;
    d.armed = 1'b1;
    if (wr_hit && wslot.hit)
    begin
      d.rw[wslot.slot] = host.wdata & fsrb_pkg::SLOT_MASK[wslot.slot];
    end
    for (int g = 0; g < fsrb_pkg::GROUPS; g++)
    begin
      // edge detect; first cycle after reset only primes history
      if (q.armed)
      begin
        set_ev[g] = ((fsrb_pkg::RISE_MASK[g] & mon[g] & ~q.prev[g]) |
                     (fsrb_pkg::FALL_MASK[g] & ~mon[g] & q.prev[g])) &
                    fsrb_pkg::LAT_MASK[g];
      end
      if (wr_hit && host.addr == fsrb_pkg::LAT_ADDR[g])
      begin
        clr_ev[g] = host.wdata;
      end
      // set wins over a clear in the same cycle
      d.lat[g] = (q.lat[g] & ~clr_ev[g]) | set_ev[g];
      d.prev[g] = mon[g];
      if (wr_hit && host.addr == fsrb_pkg::IE_ADDR[g])
      begin
        d.ie[g] = host.wdata & fsrb_pkg::IE_MASK[g];
      end
      irq_any = irq_any | (|(q.lat[g] & q.ie[g]));
    end
    if (rd_hit)
    begin
      d.rdata = fsrb_pkg::UNMAPPED_READ;
      if (wslot.hit)
      begin
        d.rdata = q.rw[wslot.slot];
      end
      for (int g = 0; g < fsrb_pkg::GROUPS; g++)
      begin
        if (host.addr == fsrb_pkg::LIVE_ADDR[g])
        begin
          d.rdata = mon[g] & fsrb_pkg::LIVE_MASK[g];
        end
        if (host.addr == fsrb_pkg::LAT_ADDR[g])
        begin
          d.rdata = q.lat[g];
        end
        if (host.addr == fsrb_pkg::IE_ADDR[g])
        begin
          d.rdata = q.ie[g];
        end
      end
      unique case (host.addr)
        fsrb_pkg::ADDR_BIT_CNT0: d.rdata = dp.bit_count[7:0];
        fsrb_pkg::ADDR_BIT_CNT1: d.rdata = dp.bit_count[15:8];
        fsrb_pkg::ADDR_BIT_CNT2: d.rdata = dp.bit_count[23:16];
        fsrb_pkg::ADDR_BIT_CNT3: d.rdata = dp.bit_count[31:24];
        fsrb_pkg::ADDR_ERR_CNT0: d.rdata = dp.err_count[7:0];
        fsrb_pkg::ADDR_ERR_CNT1: d.rdata = dp.err_count[15:8];
        fsrb_pkg::ADDR_ERR_CNT2: d.rdata = dp.err_count[23:16];
        fsrb_pkg::ADDR_FIFO_INFO:
          d.rdata = dp.fifo_info & fsrb_pkg::FIFO_INFO_MASK;
        fsrb_pkg::ADDR_RX_DATA: d.rdata = dp.rx_data;
        fsrb_pkg::ADDR_RX_TAG:
          d.rdata = dp.rx_tag & fsrb_pkg::RX_TAG_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= fsrb_pkg::RESET_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_rdata = q.rdata;
  assign ctl = q.rw;
  assign int_n = ~irq_any;
  assign rx_pop = rd_hit && host.addr == fsrb_pkg::ADDR_RX_DATA;
  assign tx_push = wr_hit && host.addr == fsrb_pkg::ADDR_TX_DATA;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_lat_write(int g);
    wr_hit && host.addr == fsrb_pkg::LAT_ADDR[g];
  endsequence

  sequence s_live_read(int g);
    rd_hit && host.addr == fsrb_pkg::LIVE_ADDR[g];
  endsequence

  sequence s_sync_rise;
    q.armed && mon[fsrb_pkg::GRP_TESTER][0] && !q.prev[0][0];
  endsequence

  generate
    for (genvar g = 0; g < fsrb_pkg::GROUPS; g++)
    begin : g_chk
      a_live_read_level: assert property (
        s_live_read(g) |=>
          host_rdata == ($past(mon[g]) & fsrb_pkg::LIVE_MASK[g]))
        else $error("live read does not match monitored level");
      a_latch_edge_set: assert property (
        q.armed |=> ((q.lat[g] & $past(set_ev[g])) == $past(set_ev[g])))
        else $error("qualifying edge did not set latched bit");
      a_w1c_clear_bit: assert property (
        s_lat_write(g) |=>
          ((q.lat[g] & $past(host.wdata) & ~$past(set_ev[g])) == 8'h00))
        else $error("write of one did not clear latched bit");
      a_clear_stays_low: assert property (
        1'b1 |=> ((q.lat[g] & ~$past(q.lat[g]) & ~$past(set_ev[g]))
                  == 8'h00))
        else $error("latched bit set without an edge");
      a_zero_write_keeps: assert property (
        s_lat_write(g) |=>
          ((q.lat[g] & $past(q.lat[g] & ~host.wdata))
           == $past(q.lat[g] & ~host.wdata)))
        else $error("write of zero changed a latched bit");
    end
  endgenerate

  a_irq_from_enable: assert property (
    (|(set_ev[0] & q.ie[0])) && !(wr_hit) |=> !int_n)
    else $error("enabled latched event did not drive interrupt");

  a_irq_holds_low: assert property (
    !int_n && !wr_hit |=> !int_n)
    else $error("interrupt released without a host write");

  a_info_no_irq: assert property (
    (q.lat[0] & q.ie[0]) == 8'h00 && (q.lat[1] & q.ie[1]) == 8'h00 &&
    (q.lat[2] & q.ie[2]) == 8'h00 |-> int_n)
    else $error("interrupt without an enabled latched bit");

  a_sync_bit_zero: assert property (
    s_sync_rise |=> (q.lat[fsrb_pkg::GRP_TESTER] &
                     fsrb_pkg::SYNC_BIT_MASK) != 8'h00)
    else $error("sync rise not latched in bit 0");

  a_ro_write_kept: assert property (
    wr_hit && wslot.hit |=>
      (ctl[$past(wslot.slot)] &
       ~fsrb_pkg::SLOT_MASK[$past(wslot.slot)]) == 8'h00)
    else $error("unused bit stored on write");

  // ----------------------------------------------------------------
  // host port checks
  // ----------------------------------------------------------------
  sequence s_ie_write(int g);
    wr_hit && host.addr == fsrb_pkg::IE_ADDR[g];
  endsequence

  sequence s_live_write(int g);
    wr_hit && host.addr == fsrb_pkg::LIVE_ADDR[g];
  endsequence

  sequence s_lat_read(int g);
    rd_hit && host.addr == fsrb_pkg::LAT_ADDR[g];
  endsequence

  sequence s_ie_read(int g);
    rd_hit && host.addr == fsrb_pkg::IE_ADDR[g];
  endsequence

  sequence s_sync_fall;
    q.armed && !mon[fsrb_pkg::GRP_TESTER][0] &&
      q.prev[fsrb_pkg::GRP_TESTER][0];
  endsequence

  generate
    for (genvar g = 0; g < fsrb_pkg::GROUPS; g++)
    begin : g_host
      a_ie_write_store: assert property (
        s_ie_write(g) |=>
          q.ie[g] == ($past(host.wdata) & fsrb_pkg::IE_MASK[g]))
        else $error("enable write not stored");

      a_lat_read_data: assert property (
        s_lat_read(g) |=> host_rdata == $past(q.lat[g]))
        else $error("latched read returned wrong value");

      a_ie_read_data: assert property (
        s_ie_read(g) |=> host_rdata == $past(q.ie[g]))
        else $error("enable read returned wrong value");

      a_lat_in_mask: assert property (
        1'b1 |-> (q.lat[g] & ~fsrb_pkg::LAT_MASK[g]) == 8'h00)
        else $error("latched bit outside defined positions");

      a_ie_in_mask: assert property (
        1'b1 |-> (q.ie[g] & ~fsrb_pkg::IE_MASK[g]) == 8'h00)
        else $error("enable bit outside defined positions");

      a_prev_follows: assert property (
        1'b1 |=> q.prev[g] == $past(mon[g]))
        else $error("edge history does not follow monitor");

      a_unarmed_no_set: assert property (
        !q.armed |-> set_ev[g] == 8'h00)
        else $error("latch set while history not primed");

      a_ie_hold_idle: assert property (
        !wr_hit |=> q.ie[g] == $past(q.ie[g]))
        else $error("enable changed without a write");

      a_lat_write_ie: assert property (
        s_lat_write(g) |=> q.ie[g] == $past(q.ie[g]))
        else $error("latched write disturbed enable");

      a_ie_write_lat: assert property (
        s_ie_write(g) |=>
          q.lat[g] == ($past(q.lat[g]) | $past(set_ev[g])))
        else $error("enable write disturbed latched bits");

      a_live_write_kept: assert property (
        s_live_write(g) |=>
          q.lat[g] == ($past(q.lat[g]) | $past(set_ev[g])) &&
          q.ie[g] == $past(q.ie[g]))
        else $error("write to live status changed state");
    end
  endgenerate

  a_rdata_holds: assert property (
    !rd_hit |=> host_rdata == $past(host_rdata))
    else $error("read data changed without a read");

  a_pop_on_read: assert property (
    rx_pop |-> rd_hit && host.addr == fsrb_pkg::ADDR_RX_DATA)
    else $error("receive pop without a data read");

  a_push_on_write: assert property (
    tx_push |-> wr_hit && host.addr == fsrb_pkg::ADDR_TX_DATA)
    else $error("transmit push without a data write");

  a_ctl_write_data: assert property (
    wr_hit && wslot.hit |=>
      ctl[$past(wslot.slot)] ==
        ($past(host.wdata) & fsrb_pkg::SLOT_MASK[$past(wslot.slot)]))
    else $error("storage write not kept");

  a_ctl_no_write: assert property (
    !wr_hit |=> ctl == $past(ctl))
    else $error("storage changed without a write");

  a_count_write_kept: assert property (
    wr_hit && host.addr == fsrb_pkg::ADDR_BIT_CNT0 |=>
      ctl == $past(ctl))
    else $error("write to counter changed storage");

  a_count_read_byte: assert property (
    rd_hit && host.addr == fsrb_pkg::ADDR_BIT_CNT0 |=>
      host_rdata == $past(dp.bit_count[7:0]))
    else $error("bit count byte read wrong");

  a_err_read_byte: assert property (
    rd_hit && host.addr == fsrb_pkg::ADDR_ERR_CNT0 |=>
      host_rdata == $past(dp.err_count[7:0]))
    else $error("error count byte read wrong");

  a_rx_tag_masked: assert property (
    rd_hit && host.addr == fsrb_pkg::ADDR_RX_TAG |=>
      (host_rdata & ~fsrb_pkg::RX_TAG_MASK) == 8'h00)
    else $error("receive tag unused bits not zero");

  a_fifo_info_masked: assert property (
    rd_hit && host.addr == fsrb_pkg::ADDR_FIFO_INFO |=>
      (host_rdata & ~fsrb_pkg::FIFO_INFO_MASK) == 8'h00)
    else $error("fifo info unused bits not zero");

  a_sync_fall_set: assert property (
    s_sync_fall |=> (q.lat[fsrb_pkg::GRP_TESTER] &
                     fsrb_pkg::SYNC_BIT_MASK) != 8'h00)
    else $error("sync fall not latched in bit 0");

  a_irq_tester_grp: assert property (
    (|(q.lat[0] & q.ie[0])) |-> !int_n)
    else $error("enabled tester latch did not interrupt");

  a_irq_link_grp: assert property (
    (|(q.lat[1] & q.ie[1])) |-> !int_n)
    else $error("enabled link latch did not interrupt");

  a_irq_alarm_grp: assert property (
    (|(q.lat[2] & q.ie[2])) |-> !int_n)
    else $error("enabled alarm latch did not interrupt");

  a_armed_after_reset: assert property (
    1'b1 |=> q.armed)
    else $error("edge history not primed after reset");

endmodule : fsrb_bank

// [logic/fsrb_pkg.sv]
// Purpose: constants and types for the framer status register bank
// Assumes: one framer, 8-bit host port, 8-bit address within the framer
// Notes: group 0 tester, group 1 link controller, group 2 alarm code

package fsrb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GROUPS = 3;
  localparam int SLOTS = 18;
  localparam int SLOT_W = 5;
  localparam int GRP_TESTER = 0;

  // ----------------------------------------------------------------
  // status triplets: live, latched, enable
  // ----------------------------------------------------------------
  localparam logic [GROUPS-1:0][7:0] LIVE_ADDR = {8'h61, 8'h54, 8'h38};
  localparam logic [GROUPS-1:0][7:0] LAT_ADDR = {8'h62, 8'h55, 8'h39};
  localparam logic [GROUPS-1:0][7:0] IE_ADDR = {8'h63, 8'h56, 8'h3a};
  localparam logic [GROUPS-1:0][7:0] LIVE_MASK = {8'h0f, 8'h0c, 8'h37};
  localparam logic [GROUPS-1:0][7:0] LAT_MASK = {8'h1f, 8'hff, 8'h3f};
  localparam logic [GROUPS-1:0][7:0] IE_MASK = {8'h1f, 8'hff, 8'h0f};
  localparam logic [GROUPS-1:0][7:0] RISE_MASK = {8'h1f, 8'hff, 8'h3f};
  localparam logic [GROUPS-1:0][7:0] FALL_MASK = {8'h00, 8'h00, 8'h01};
  localparam logic [7:0] SYNC_BIT_MASK = 8'h01;

  // ----------------------------------------------------------------
  // host-writable storage slots
  // ----------------------------------------------------------------
  localparam logic [SLOTS-1:0][7:0] SLOT_ADDR = {
    8'h66, 8'h65, 8'h64, 8'h60, 8'h5f, 8'h5e, 8'h51, 8'h50, 8'h3f,
    8'h3e, 8'h3d, 8'h3c, 8'h33, 8'h32, 8'h31, 8'h30, 8'h2b, 8'h2a};
  localparam logic [SLOTS-1:0][7:0] SLOT_MASK = {
    8'h3f, 8'h3f, 8'h3f, 8'h07, 8'h01, 8'hff, 8'h77, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff};

  // ----------------------------------------------------------------
  // datapath-owned locations, read-only except ADDR_TX_DATA, which is also a writable storage slot
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BIT_CNT0 = 8'h40;
  localparam logic [7:0] ADDR_BIT_CNT1 = 8'h41;
  localparam logic [7:0] ADDR_BIT_CNT2 = 8'h42;
  localparam logic [7:0] ADDR_BIT_CNT3 = 8'h43;
  localparam logic [7:0] ADDR_ERR_CNT0 = 8'h44;
  localparam logic [7:0] ADDR_ERR_CNT1 = 8'h45;
  localparam logic [7:0] ADDR_ERR_CNT2 = 8'h46;
  localparam logic [7:0] ADDR_FIFO_INFO = 8'h57;
  localparam logic [7:0] ADDR_RX_DATA = 8'h5c;
  localparam logic [7:0] ADDR_RX_TAG = 8'h5d;
  localparam logic [7:0] ADDR_TX_DATA = 8'h5e;
  localparam logic [7:0] FIFO_INFO_MASK = 8'h3f;
  localparam logic [7:0] RX_TAG_MASK = 8'h0f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [GROUPS-1:0][7:0] fsrb_grp_t;
  typedef logic [SLOTS-1:0][7:0] fsrb_rw_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsrb_host_t;

  typedef struct packed {
    logic [31:0] bit_count;
    logic [23:0] err_count;
    logic [7:0] fifo_info;
    logic [7:0] rx_data;
    logic [7:0] rx_tag;
  } fsrb_dp_t;

  typedef struct packed {
    logic hit;
    logic [SLOT_W-1:0] slot;
  } fsrb_slot_t;

  typedef struct packed {
    fsrb_rw_t rw;
    fsrb_grp_t prev;
    fsrb_grp_t lat;
    fsrb_grp_t ie;
    logic armed;
    logic [7:0] rdata;
  } fsrb_state_t;

  localparam fsrb_state_t RESET_STATE = '0;

  // ----------------------------------------------------------------
  // address to storage slot
  // ----------------------------------------------------------------
  function automatic fsrb_slot_t fsrb_slot_of(input logic [7:0] addr);
    fsrb_slot_t r;
    r = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (SLOT_ADDR[i] == addr)
      begin
        r.hit = 1'b1;
        r.slot = SLOT_W'(i);
      end
    end
    return r;
  endfunction : fsrb_slot_of

endpackage : fsrb_pkg

// [verification/tb_top.sv]
// Purpose: self-checking bench for the framer status register bank
// Assumes: one-cycle host strobes, read data one cycle after strobe
// Notes: idle latch and interrupt check first, then table rows, then status, latch and interrupt cases
`timescale 1ns/100ps
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } fsrb_row_t;
  localparam int ROWS = 20;
  localparam fsrb_row_t ROW [ROWS] = '{
    '{8'h2a, 8'hff, 8'hff}, '{8'h2b, 8'h5a, 8'h5a}, '{8'h30, 8'ha5, 8'ha5},
    '{8'h31, 8'h7f, 8'h7f}, '{8'h32, 8'h0f, 8'h0f}, '{8'h33, 8'h3c, 8'h3c},
    '{8'h3c, 8'h81, 8'h81}, '{8'h3f, 8'h18, 8'h18}, '{8'h51, 8'h77, 8'h77},
    '{8'h5f, 8'h01, 8'h01}, '{8'h60, 8'h07, 8'h07}, '{8'h64, 8'h3f, 8'h3f},
    '{8'h66, 8'h3f, 8'h3f}, '{8'h34, 8'h00, 8'h00}, '{8'h7b, 8'h00, 8'h00},
    '{8'h38, 8'h37, 8'h00}, '{8'h40, 8'hff, 8'h11}, '{8'h44, 8'hff, 8'h44},
    '{8'h5d, 8'h0f, 8'h0f}, '{8'h3a, 8'h0f, 8'h0f}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  fsrb_pkg::fsrb_host_t host = '0;
  fsrb_pkg::fsrb_grp_t mon = '0;
  fsrb_pkg::fsrb_dp_t dp = '{32'h44332211, 24'h665544, 8'hff, 8'h9c, 8'hff};
  logic [7:0] host_rdata;
  fsrb_pkg::fsrb_rw_t ctl;
  logic rx_pop;
  logic tx_push;
  logic int_n;
  logic [7:0] rd;
  logic pop_seen;
  logic push_seen;
  int n_errors = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  fsrb_bank u_fsrb_bank (.clk(clk), .rst(rst), .host(host),
    .host_rdata(host_rdata), .mon(mon), .dp(dp), .ctl(ctl),
    .rx_pop(rx_pop), .tx_push(tx_push), .int_n(int_n));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    host <= '{sel: 1'b1, wr: w, rd: ~w, addr: a, wdata: d};
    #1;
    pop_seen = rx_pop;
    push_seen = tx_push;
    @(posedge clk);
    host <= '0;
    #1;
    rd = host_rdata;
  endtask : acc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdchk

  // monitored level change, then let the edge reach the latch
  task automatic mset(input int g, input logic [7:0] v);
    @(posedge clk);
    mon[g] <= v;
    repeat (3) @(posedge clk);
  endtask : mset

  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h39, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    for (int i = 0; i < ROWS; i++)
    begin
      acc(1'b1, ROW[i].a, ROW[i].w);
      rdchk(ROW[i].a, ROW[i].e);
    end
    chk(ctl[0], 8'hff);
    mset(0, 8'hff);
    rdchk(8'h39, 8'h3f);
    chk({7'h00, int_n}, 8'h00);
    rdchk(8'h38, 8'h37);
    acc(1'b1, 8'h39, 8'h00);
    rdchk(8'h39, 8'h3f);
    acc(1'b1, 8'h39, 8'h01);
    rdchk(8'h39, 8'h3e);
    chk({7'h00, int_n}, 8'h00);
    acc(1'b1, 8'h3a, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    acc(1'b1, 8'h39, 8'h3e);
    repeat (3) @(posedge clk);
    rdchk(8'h39, 8'h00);
    acc(1'b1, 8'h3a, 8'h01);
    mset(0, 8'hfe);
    rdchk(8'h39, 8'h01);
    chk({7'h00, int_n}, 8'h00);
    acc(1'b1, 8'h39, 8'h01);
    chk({7'h00, int_n}, 8'h01);
    rdchk(8'h38, 8'h36);
    mset(0, 8'h00);
    rdchk(8'h39, 8'h00);
    mset(1, 8'h80);
    rdchk(8'h55, 8'h80);
    acc(1'b1, 8'h55, 8'h80);
    mset(2, 8'h10);
    rdchk(8'h62, 8'h10);
    rdchk(8'h61, 8'h00);
    acc(1'b1, 8'h63, 8'h10);
    chk({7'h00, int_n}, 8'h00);
    acc(1'b1, 8'h62, 8'h10);
    chk({7'h00, int_n}, 8'h01);
    @(posedge clk);
    dp.fifo_info <= 8'h00;
    repeat (3) @(posedge clk);
    chk({7'h00, int_n}, 8'h01);
    rdchk(8'h57, 8'h00);
    rdchk(8'h5c, 8'h9c);
    chk({7'h00, pop_seen}, 8'h01);
    acc(1'b1, 8'h5e, 8'h42);
    chk({6'h00, push_seen, pop_seen}, 8'h02);
    mset(2, 8'h00);
    mset(2, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h62, 8'h00);
    chk(ctl[0], 8'h00);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    close_out();
  end
endmodule : tb_top
